// ---- design/erds_pkg.sv ----
// Purpose: shared constants for the receive descriptor status engine
// Assumes: eight-word descriptors, 32-bit words, byte-wide receive stream
// Notes:   word indices are descriptor word numbers, not byte offsets
package erds_pkg;
    // ------------------------------------------------------------
    // descriptor layout
    // ------------------------------------------------------------
    localparam int          DESC_WORDS = 8;
    localparam logic [2:0]  W_STATUS   = 3'h0;
    localparam logic [2:0]  W_CTRL     = 3'h1;
    localparam logic [2:0]  W_BUF1     = 3'h2;
    localparam logic [2:0]  W_NEXT     = 3'h3;
    localparam logic [2:0]  W_EXT      = 3'h4;
    localparam logic [2:0]  W_RSVD     = 3'h5;
    localparam logic [2:0]  W_TS_LO    = 3'h6;
    localparam logic [2:0]  W_TS_HI    = 3'h7;
    localparam int          BUF1_SIZE_MSB = 12;
    // ------------------------------------------------------------
    // status word and extended status word bit positions
    // ------------------------------------------------------------
    localparam int B_OWN   = 31;
    localparam int B_DAF   = 30;
    localparam int B_FL_HI = 29;
    localparam int B_FL_LO = 16;
    localparam int B_ES    = 15;
    localparam int B_DE    = 14;
    localparam int B_SAF   = 13;
    localparam int B_LE    = 12;
    localparam int B_OE    = 11;
    localparam int B_FS    = 9;
    localparam int B_LS    = 8;
    localparam int B_GF    = 7;
    localparam int B_LC    = 6;
    localparam int B_FT    = 5;
    localparam int B_RWT   = 4;
    localparam int B_RE    = 3;
    localparam int B_CE    = 1;
    localparam int B_IPH   = 3;
    localparam int B_IPP   = 4;
    // ------------------------------------------------------------
    // frame constants and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] ETHERTYPE_MIN    = 16'h0600;
    localparam logic [13:0] IPC_APPEND_BYTES = 14'h0002;
    localparam logic [13:0] HDR_CRC_BYTES    = 14'h0012;
    localparam logic [31:0] RST_WORD         = 32'h0000_0000;
endpackage

// ---- design/erds_lt_classify.sv ----
// Purpose: classify the length/type field and check the length
// Assumes: i_frame_len counts header, payload and crc bytes
// Notes:   mismatch is forced low for ethertype frames
`timescale 1ns/1ps
module erds_lt_classify
    import erds_pkg::*;
(
    input  wire logic [15:0] i_lt_field,
    input  wire logic [13:0] i_frame_len,
    output logic             o_ethertype,
    output logic             o_len_mismatch
);
    logic [13:0] payload_len;

    always_comb begin
        payload_len    = i_frame_len - HDR_CRC_BYTES;
        o_ethertype    = (i_lt_field >= ETHERTYPE_MIN);
        o_len_mismatch = !o_ethertype && (i_lt_field != {2'h0, payload_len});
    end
endmodule

// ---- design/erds_status_pack.sv ----
// Purpose: assemble the status word written back to a descriptor
// Assumes: all inputs are held stable while the word is written
// Notes:   ownership is always returned to software here
`timescale 1ns/1ps
module erds_status_pack
    import erds_pkg::*;
(
    input  wire logic [13:0] i_frame_byte_count,
    input  wire logic        i_dest_addr_filter_fail,
    input  wire logic        i_src_addr_filter_fail,
    input  wire logic        i_descriptor_truncation_error,
    input  wire logic        i_length_mismatch_error,
    input  wire logic        i_overflow,
    input  wire logic        i_first_segment_flag,
    input  wire logic        i_last_segment_flag,
    input  wire logic        i_giant,
    input  wire logic        i_late_coll,
    input  wire logic        i_ethertype_frame_flag,
    input  wire logic        i_wdog_timeout,
    input  wire logic        i_rx_err,
    input  wire logic        i_crc_err,
    input  wire logic        i_ip_hdr_err,
    input  wire logic        i_ip_pay_err,
    output logic [31:0]      o_rx_desc_status_word
);
    logic error_summary_flag;

    always_comb begin
        error_summary_flag = i_crc_err | i_rx_err | i_wdog_timeout | i_late_coll | i_giant
                           | i_ip_hdr_err | i_ip_pay_err | i_overflow
                           | i_descriptor_truncation_error;
        o_rx_desc_status_word                 = RST_WORD;
        o_rx_desc_status_word[B_OWN]          = 1'b0;
        o_rx_desc_status_word[B_DAF]          = i_dest_addr_filter_fail;
        o_rx_desc_status_word[B_FL_HI:B_FL_LO] = i_frame_byte_count;
        o_rx_desc_status_word[B_ES]           = error_summary_flag;
        o_rx_desc_status_word[B_DE]           = i_descriptor_truncation_error;
        o_rx_desc_status_word[B_SAF]          = i_src_addr_filter_fail;
        o_rx_desc_status_word[B_LE]           = i_length_mismatch_error;
        o_rx_desc_status_word[B_OE]           = i_overflow;
        o_rx_desc_status_word[B_FS]           = i_first_segment_flag;
        o_rx_desc_status_word[B_LS]           = i_last_segment_flag;
        o_rx_desc_status_word[B_GF]           = i_giant;
        o_rx_desc_status_word[B_LC]           = i_late_coll;
        o_rx_desc_status_word[B_FT]           = i_ethertype_frame_flag;
        o_rx_desc_status_word[B_RWT]          = i_wdog_timeout;
        o_rx_desc_status_word[B_RE]           = i_rx_err;
        o_rx_desc_status_word[B_CE]           = i_crc_err;
    end
endmodule

// ---- design/erds_top.sv ----
// Purpose: receive descriptor engine: stores frame bytes, writes back status
// Assumes: fetch logic presents descriptor words 0..2 and the next owner bit
// Notes:   status word is written last so ownership flips after the data
`timescale 1ns/1ps
module erds_top
    import erds_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_desc_load,
    input  wire logic [31:0] i_desc_word0,
    input  wire logic [31:0] i_desc_word1,
    input  wire logic [31:0] i_desc_word2,
    input  wire logic        i_next_desc_own,
    input  wire logic        i_rx_valid,
    input  wire logic [7:0]  i_rx_byte,
    input  wire logic        i_rx_last,
    output logic             o_rx_ready,
    input  wire logic [15:0] i_lt_field,
    input  wire logic        i_crc_err,
    input  wire logic        i_rx_err,
    input  wire logic        i_wdog_timeout,
    input  wire logic        i_late_coll,
    input  wire logic        i_giant,
    input  wire logic        i_ip_hdr_err,
    input  wire logic        i_ip_pay_err,
    input  wire logic        i_mtl_overflow,
    input  wire logic        i_da_fail,
    input  wire logic        i_sa_fail,
    input  wire logic        i_ipc_type1_en,
    input  wire logic        i_ctrl_frame,
    input  wire logic        i_ts_valid,
    input  wire logic [63:0] i_ts,
    output logic             o_wr_valid,
    output logic [31:0]      o_wr_addr,
    output logic [7:0]       o_wr_byte,
    output logic             o_wb_valid,
    output logic [2:0]       o_wb_index,
    output logic [31:0]      o_wb_data,
    output logic             o_desc_req,
    output logic             o_busy
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_NODESC,
        ST_RECV,
        ST_DROP,
        ST_WB_EXT,
        ST_WB_TSL,
        ST_WB_TSH,
        ST_WB_STAT
    } erds_state_e;

    typedef struct packed {
        erds_state_e state;
        logic [12:0] buf_size;
        logic [31:0] buf_addr;
        logic [12:0] buf_cnt;
        logic [13:0] frame_cnt;
        logic        in_frame;
        logic        first_here;
        logic        last_here;
        logic        trunc;
        logic [15:0] lt;
        logic [9:0]  err;
        logic        add_two;
        logic        ts_ok;
        logic [63:0] ts;
        logic        wb_valid;
        logic [2:0]  wb_index;
        logic [31:0] wb_data;
        logic        wr_valid;
        logic [31:0] wr_addr;
        logic [7:0]  wr_byte;
        logic        desc_req;
    } erds_state_s;

    localparam int E_CRC = 0;
    localparam int E_RE  = 1;
    localparam int E_RWT = 2;
    localparam int E_LC  = 3;
    localparam int E_GF  = 4;
    localparam int E_IPH = 5;
    localparam int E_IPP = 6;
    localparam int E_OE  = 7;
    localparam int E_DAF = 8;
    localparam int E_SAF = 9;

    erds_state_s state_ff;
    erds_state_s nxt_state;
    logic [31:0] status_word;
    logic [13:0] fl_value;
    logic        ethertype;
    logic        len_mismatch;
    logic        buf_full;

    // ------------------------------------------------------------
    // end-of-frame capture, shared by receive and drop states
    // ------------------------------------------------------------
    function automatic erds_state_s capture_eof(input erds_state_s s);
        erds_state_s r;
        r            = s;
        r.err        = {i_sa_fail, i_da_fail, i_mtl_overflow, i_ip_pay_err, i_ip_hdr_err,
                        i_giant, i_late_coll, i_wdog_timeout, i_rx_err, i_crc_err};
        r.lt         = i_lt_field;
        r.add_two    = i_ipc_type1_en && !i_ctrl_frame;
        r.ts         = i_ts;
        r.ts_ok      = i_ts_valid;
        r.last_here  = 1'b1;
        r.state      = ST_WB_EXT;
        return r;
    endfunction

    // ------------------------------------------------------------
    // status assembly
    // ------------------------------------------------------------
    // appended checksum bytes never reach the buffer, so add them here
    assign fl_value = state_ff.add_two ? state_ff.frame_cnt + IPC_APPEND_BYTES
                                       : state_ff.frame_cnt;

    erds_lt_classify u_classify (
        .i_lt_field     (state_ff.lt),
        .i_frame_len    (fl_value),
        .o_ethertype    (ethertype),
        .o_len_mismatch (len_mismatch)
    );

    erds_status_pack u_pack (
        .i_frame_byte_count            (fl_value),
        .i_dest_addr_filter_fail       (state_ff.err[E_DAF]),
        .i_src_addr_filter_fail        (state_ff.err[E_SAF]),
        .i_descriptor_truncation_error (state_ff.trunc),
        .i_length_mismatch_error       (state_ff.last_here && len_mismatch),
        .i_overflow                    (state_ff.err[E_OE]),
        .i_first_segment_flag          (state_ff.first_here),
        .i_last_segment_flag           (state_ff.last_here),
        .i_giant                       (state_ff.err[E_GF]),
        .i_late_coll                   (state_ff.err[E_LC]),
        .i_ethertype_frame_flag        (state_ff.last_here && ethertype),
        .i_wdog_timeout                (state_ff.err[E_RWT]),
        .i_rx_err                      (state_ff.err[E_RE]),
        .i_crc_err                     (state_ff.err[E_CRC]),
        .i_ip_hdr_err                  (state_ff.err[E_IPH]),
        .i_ip_pay_err                  (state_ff.err[E_IPP]),
        .o_rx_desc_status_word         (status_word)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    assign buf_full   = (state_ff.buf_cnt == state_ff.buf_size);
    // a byte that does not fit is held back until a decision is made
    assign o_rx_ready = ((state_ff.state == ST_RECV) && !buf_full) || (state_ff.state == ST_DROP);

    always_comb begin
        nxt_state          = state_ff;
        nxt_state.wb_valid = 1'b0;
        nxt_state.wr_valid = 1'b0;
        nxt_state.desc_req = 1'b0;
        case (state_ff.state)
            ST_NODESC: begin
                // a descriptor still owned by software is ignored
                if (i_desc_load && i_desc_word0[B_OWN]) begin
                    nxt_state.buf_size   = i_desc_word1[BUF1_SIZE_MSB:0];
                    nxt_state.buf_addr   = i_desc_word2;
                    nxt_state.buf_cnt    = 13'h0000;
                    nxt_state.first_here = 1'b0;
                    nxt_state.last_here  = 1'b0;
                    nxt_state.trunc      = 1'b0;
                    nxt_state.err        = 10'h000;
                    nxt_state.state      = ST_RECV;
                end
            end
            ST_RECV: begin
                if (i_rx_valid && !buf_full) begin
                    nxt_state.wr_valid  = 1'b1;
                    nxt_state.wr_addr   = state_ff.buf_addr + {19'h00000, state_ff.buf_cnt};
                    nxt_state.wr_byte   = i_rx_byte;
                    nxt_state.buf_cnt   = state_ff.buf_cnt + 13'h0001;
                    nxt_state.frame_cnt = state_ff.frame_cnt + 14'h0001;
                    if (!state_ff.in_frame) begin
                        // zero-size buffers pass the first mark onward
                        nxt_state.first_here = 1'b1;
                        nxt_state.in_frame   = 1'b1;
                        nxt_state.frame_cnt  = 14'h0001;
                    end
                    if (i_rx_last) begin
                        nxt_state = capture_eof(nxt_state);
                    end
                end else if (i_rx_valid && buf_full) begin
                    if (i_next_desc_own) begin
                        nxt_state.state = ST_WB_STAT;
                    end else begin
                        nxt_state.trunc = 1'b1;
                        nxt_state.state = ST_DROP;
                    end
                end
            end
            ST_DROP: begin
                if (i_rx_valid && i_rx_last) begin
                    nxt_state = capture_eof(state_ff);
                end
            end
            ST_WB_EXT: begin
                nxt_state.wb_valid       = 1'b1;
                nxt_state.wb_index       = W_EXT;
                nxt_state.wb_data        = RST_WORD;
                nxt_state.wb_data[B_IPH] = state_ff.err[E_IPH];
                nxt_state.wb_data[B_IPP] = state_ff.err[E_IPP];
                nxt_state.state          = state_ff.ts_ok ? ST_WB_TSL : ST_WB_STAT;
            end
            ST_WB_TSL: begin
                nxt_state.wb_valid = 1'b1;
                nxt_state.wb_index = W_TS_LO;
                nxt_state.wb_data  = state_ff.ts[31:0];
                nxt_state.state    = ST_WB_TSH;
            end
            ST_WB_TSH: begin
                nxt_state.wb_valid = 1'b1;
                nxt_state.wb_index = W_TS_HI;
                nxt_state.wb_data  = state_ff.ts[63:32];
                nxt_state.state    = ST_WB_STAT;
            end
            ST_WB_STAT: begin
                nxt_state.wb_valid = 1'b1;
                nxt_state.wb_index = W_STATUS;
                nxt_state.wb_data  = status_word;
                nxt_state.desc_req = 1'b1;
                nxt_state.state    = ST_NODESC;
                if (state_ff.last_here) begin
                    nxt_state.in_frame = 1'b0;
                end
            end
            default: begin
                nxt_state.state = ST_NODESC;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            state_ff       <= '0;
            state_ff.state <= ST_NODESC;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_wr_valid = state_ff.wr_valid;
    assign o_wr_addr  = state_ff.wr_addr;
    assign o_wr_byte  = state_ff.wr_byte;
    assign o_wb_valid = state_ff.wb_valid;
    assign o_wb_index = state_ff.wb_index;
    assign o_wb_data  = state_ff.wb_data;
    assign o_desc_req = state_ff.desc_req;
    assign o_busy     = state_ff.in_frame;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_ts_lo_write;
        o_wb_valid && (o_wb_index == W_TS_LO);
    endsequence

    sequence s_ts_hi_then_status;
        (o_wb_valid && (o_wb_index == W_TS_HI)) ##1 (o_wb_valid && (o_wb_index == W_STATUS));
    endsequence

    AST_TS_PAIR: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_ts_lo_write |=> s_ts_hi_then_status)
        else $error("timestamp words not written in order");

    AST_OWN_RETURNED: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (o_wb_valid && (o_wb_index == W_STATUS)) |-> (!o_wb_data[B_OWN] && o_desc_req))
        else $error("status write kept ownership or skipped request");

    AST_NO_OVERRUN: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (state_ff.state == ST_RECV)
        |-> ((state_ff.buf_cnt <= state_ff.buf_size) && !(buf_full && o_rx_ready)))
        else $error("byte accepted into a full buffer");

    AST_TRUNC_DROP: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        ((state_ff.state == ST_RECV) && buf_full && i_rx_valid && !i_next_desc_own)
        |=> ((state_ff.state == ST_DROP) && state_ff.trunc))
        else $error("full buffer with unowned next did not truncate");

    AST_ERR_SUMMARY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (o_wb_valid && (o_wb_index == W_STATUS) && (o_wb_data[B_OE] || o_wb_data[B_DE]
         || o_wb_data[B_CE] || o_wb_data[B_GF])) |-> o_wb_data[B_ES])
        else $error("error summary missing");

    AST_LEN_ONLY_8023: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (o_wb_valid && (o_wb_index == W_STATUS) && o_wb_data[B_LE]) |-> !o_wb_data[B_FT])
        else $error("length error on ethertype frame");

    AST_LAST_PATH: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (o_wb_valid && (o_wb_index == W_STATUS) && !o_wb_data[B_LS])
        |-> ($past(state_ff.state, 2) == ST_RECV))
        else $error("non-last close did not come from receive");

    AST_OWNED_ONLY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        ((state_ff.state == ST_NODESC) && i_desc_load && !i_desc_word0[B_OWN])
        |=> (state_ff.state == ST_NODESC))
        else $error("software-owned descriptor was taken");

    AST_FL_APPEND: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        ((state_ff.state == ST_WB_STAT) && state_ff.add_two)
        |=> (o_wb_data[B_FL_HI:B_FL_LO] == $past(state_ff.frame_cnt) + IPC_APPEND_BYTES))
        else $error("appended bytes missing from frame length");
endmodule

// ---- bench/erds_host_model.sv ----
// Purpose: host side that hands owned descriptors to the engine
// Assumes: one buffer per descriptor, buffer two left unused
// Notes:   words read back inverted whenever no load is presented
`timescale 1ns/1ps
module erds_host_model
    import erds_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_desc_req,
    input  wire logic        i_kick,
    input  wire logic        i_chain,
    input  wire logic        i_own,
    input  wire logic [12:0] i_size,
    input  wire logic [31:0] i_addr,
    output logic             o_desc_load,
    output logic [31:0]      o_w0,
    output logic [31:0]      o_w1,
    output logic [31:0]      o_w2
);
    // ----------------------------------------
    // descriptor hand-over
    // ----------------------------------------
    logic [31:0] w0;
    logic [31:0] w1;
    // fields are complete in the same word set that grants ownership
    assign w0   = {i_own, 31'h0000_0000};
    assign w1   = {19'h0, i_size};
    // stale words must not look valid outside the load cycle
    assign o_w0 = o_desc_load ? w0 : ~w0;
    assign o_w1 = o_desc_load ? w1 : ~w1;
    assign o_w2 = o_desc_load ? i_addr : ~i_addr;
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_desc_load <= 1'b0;
        end else begin
            o_desc_load <= i_kick | (i_desc_req & i_chain);
        end
    end
endmodule

// ---- bench/erds_top_tb.sv ----
// Purpose: random and corner frames through the descriptor engine
// Assumes: host model hands out one descriptor per kick or chained request
// Notes:   status is judged from the write-back of each descriptor
`timescale 1ns/1ps
module erds_top_tb
    import erds_pkg::*;
();
    localparam logic [31:0] BASE = 32'h0000_1000;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        kick = 1'b0;
    logic        chain = 1'b0;
    logic        own = 1'b1;
    logic        next_own = 1'b0;
    logic        rx_valid = 1'b0;
    logic        rx_last = 1'b0;
    logic        ipc = 1'b0;
    logic        ctrl = 1'b0;
    logic        ts_valid = 1'b0;
    logic [7:0]  rx_byte = 8'h00;
    logic [9:0]  er = 10'h000;
    logic [12:0] size = 13'h0040;
    logic [15:0] lt = 16'h0000;
    logic [63:0] ts = 64'h0;
    logic        load, rx_ready, wr_v, wb_v, dreq, busy;
    logic [31:0] w0, w1, w2, wr_addr, wb_d;
    logic [7:0]  wr_byte;
    logic [2:0]  wb_i;
    logic [31:0] wb [8];
    logic [31:0] sq [$];
    logic [7:0]  bq [$];
    int          nwr, fails, comparisons;

    always #12.5 clk = ~clk;

    erds_host_model u_erds_host_model (.i_sys_clk(clk), .i_rst_n(rst_n), .i_desc_req(dreq),
        .i_kick(kick), .i_chain(chain), .i_own(own), .i_size(size), .i_addr(BASE),
        .o_desc_load(load), .o_w0(w0), .o_w1(w1), .o_w2(w2));
    erds_top u_erds_top (.i_sys_clk(clk), .i_rst_n(rst_n), .i_desc_load(load), .i_desc_word0(w0),
        .i_desc_word1(w1), .i_desc_word2(w2), .i_next_desc_own(next_own), .i_rx_valid(rx_valid),
        .i_rx_byte(rx_byte), .i_rx_last(rx_last), .o_rx_ready(rx_ready), .i_lt_field(lt),
        .i_crc_err(er[0]), .i_rx_err(er[1]), .i_wdog_timeout(er[2]), .i_late_coll(er[3]),
        .i_giant(er[4]), .i_ip_hdr_err(er[5]), .i_ip_pay_err(er[6]), .i_mtl_overflow(er[7]),
        .i_da_fail(er[8]), .i_sa_fail(er[9]), .i_ipc_type1_en(ipc), .i_ctrl_frame(ctrl),
        .i_ts_valid(ts_valid), .i_ts(ts), .o_wr_valid(wr_v), .o_wr_addr(wr_addr),
        .o_wr_byte(wr_byte), .o_wb_valid(wb_v), .o_wb_index(wb_i), .o_wb_data(wb_d),
        .o_desc_req(dreq), .o_busy(busy));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] exp_word(input logic [13:0] c, input logic de);
        logic [31:0] w;
        logic        ft;
        ft       = (lt >= ETHERTYPE_MIN);
        w        = 32'h0000_0000;
        w[30]    = er[8];
        w[29:16] = c;
        w[15]    = (|er[7:0]) | de;
        w[14:11] = {de, er[9], !ft && (lt != {2'h0, c} - 16'h0012), er[7]};
        w[9:8]   = 2'h3;
        w[7:3]   = {er[4], er[3], ft, er[2], er[1]};
        w[1]     = er[0];
        return w;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        if (wr_v) begin
            chk(wr_addr, BASE + nwr);
            chk({24'h0, wr_byte}, {24'h0, bq.pop_front()});
            nwr++;
        end
        if (wb_v) wb[wb_i] = wb_d;
        if (dreq) begin
            sq.push_back(wb[0]);
            nwr = 0;
        end
    end

    // byte stream with a bounded wait on every handshake
    task automatic frame(input int n, input logic [12:0] sz, input logic no);
        int k;
        size     <= sz;
        next_own <= no;
        kick     <= 1'b1;
        sq = {};
        bq = {};
        nwr = 0;
        foreach (wb[i]) wb[i] = 'x;
        @(posedge clk);
        kick <= 1'b0;
        for (int i = 0; i < n; i++) begin
            rx_valid <= 1'b1;
            rx_byte  <= 8'($urandom);
            rx_last  <= (i == n - 1);
            k = 0;
            do begin
                @(posedge clk);
                k++;
            end while (!rx_ready && k < 60);
            if (!rx_ready) begin
                fails++;
                wrap_up();
            end
            bq.push_back(rx_byte);
        end
        rx_valid <= 1'b0;
        rx_last  <= 1'b0;
        k = 0;
        while (!dreq && k < 60) begin
            @(posedge clk);
            k++;
        end
        if (!dreq) fails++;
        @(posedge clk);
        chk({31'h0, busy}, 32'h0);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int   n;
        int   c;
        logic a;
        logic b;
        void'($urandom(18066));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int k = 0; k < 8; k++) begin
            n = $urandom_range(20, 60);
            a = 1'($urandom);
            b = 1'($urandom);
            c = n + ((a && !b) ? 2 : 0);
            ipc      <= a;
            ctrl     <= b;
            ts_valid <= 1'($urandom);
            ts       <= {$urandom, $urandom};
            er       <= ($urandom_range(0, 1) != 0) ? 10'($urandom) : 10'h000;
            case (k % 4)
                0: lt <= ETHERTYPE_MIN + 16'(k);
                1: lt <= 16'(c - 18);
                2: lt <= ETHERTYPE_MIN - 16'h0001;
                default: lt <= 16'($urandom_range(0, 1499));
            endcase
            frame(n, 13'h0040, 1'b0);
            chk(sq[$], exp_word(14'(c), 1'b0));
            chk(wb[4], {27'h0, er[6], er[5], 3'h0});
            if (ts_valid) chk(wb[6], ts[31:0]);
            if (ts_valid) chk(wb[7], ts[63:32]);
            $display("random frame %0d done", k);
        end
        own  <= 1'b0;
        kick <= 1'b1;
        @(posedge clk);
        kick <= 1'b0;
        repeat (4) @(posedge clk);
        chk({31'h0, rx_ready}, 32'h0);
        own  <= 1'b1;
        $display("unowned descriptor done");
        er       <= 10'h000;
        ipc      <= 1'b0;
        ts_valid <= 1'b0;
        lt       <= 16'h0800;
        frame(12, 13'h0008, 1'b0);
        chk(sq[$], exp_word(14'h0008, 1'b1));
        $display("truncation done");
        chain <= 1'b1;
        frame(12, 13'h0008, 1'b1);
        chk(32'(sq.size()), 32'h2);
        chk({29'h0, sq[0][31], sq[0][9:8]}, 32'h2);
        chk({29'h0, sq[1][31], sq[1][9:8]}, 32'h1);
        $display("spill done");
        wrap_up();
    end
endmodule
